// ### design/ush_pkg.sv
// Shared constants and types for the universal shift block
package ush_pkg;

  // =========================================
  // Widths and counts
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam int SYNC_STAGES = 3;

  // =========================================
  // Wire modes
  localparam logic [1:0] WM_OFF = 2'h0;
  localparam logic [1:0] WM_THREE = 2'h1;
  localparam logic [1:0] WM_TWO = 2'h2;
  localparam logic [1:0] WM_TWO_OVF = 2'h3;

  // =========================================
  // Clock sources
  localparam logic [1:0] SRC_SOFT = 2'h0;
  localparam logic [1:0] SRC_TIMER = 2'h1;
  localparam logic [1:0] SRC_EXT = 2'h2;
  localparam logic [1:0] SRC_EXT_TOG = 2'h3;

  // =========================================
  // Control write image
  typedef struct packed {
    logic [1:0] wire_mode_select;
    logic [1:0] clock_source_select;
    logic edge_select_bit;
    logic master;
    logic shift_clock_strobe;
    logic clock_toggle_strobe;
  } ush_ctrl_t;

  // Status write image
  typedef struct packed {
    logic ovf_clr;
    logic start_clr;
    logic [3:0] cnt;
  } ush_stat_t;

  // Serial clock event passed from the link domain
  typedef struct packed {
    logic level;
    logic din;
  } ush_edge_t;

endpackage : ush_pkg

// ### design/ush_evsync.sv
// Toggle to pulse crossing into the system clock domain
`timescale 1ns/1ps
module ush_evsync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic tog_in,
  output logic pulse_out
);

  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
    end else begin
      s1_r <= tog_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign pulse_out = s2_r ^ s3_r;

endmodule : ush_evsync

// ### design/ush_shift_top.sv
// Universal shift block: shift register, edge counter, clock control
// =========================================
// Functional notes
// RULE1: Unbuffered 8-bit shift register on data port
// RULE2: MSB drives output pin chosen by mode
// RULE3: Output latch changes on opposite edge
// RULE4: Serial input always from data pin
// RULE5: Readable writable 4-bit counter with overflow
// RULE6: Register and counter share clock source
// RULE7: External clock counts both edges
// RULE8: Source: pin, timer match, software strobe
// RULE9: Two-wire start condition raises flag
// RULE10: Two-wire holds clock low after events
// RULE11: Three-wire SPI modes 0/1, no select
// RULE12: Master clock toggles by port or strobe
// RULE13: Edge select swaps sample and shift edges
// RULE14: Parties set data half period early
// RULE15: Software clears counter before each byte
// RULE16: Sixteen edges overflow and flag byte done
// RULE17: Overflow flag wakes from idle
// RULE18: Two-wire start wakes from any sleep
// RULE19: Status write clears flag, loads counter
// RULE20: Alternating strobes reach half system clock
// RULE21: Sixteen toggle writes finish one byte
// RULE22: Shift strobe shifts and counts once
`timescale 1ns/1ps
module ush_shift_top
  import ush_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic LINK_CLK_IN,
  input wire logic SCK_PIN_IN,
  input wire logic SDI_PIN_IN,
  input wire logic DATA_WR_IN,
  input wire logic [DW-1:0] DATA_IN,
  input wire logic CTRL_WR_IN,
  input wire ush_ctrl_t CTRL_IN,
  input wire logic STAT_WR_IN,
  input wire ush_stat_t STAT_IN,
  input wire logic TIMER_MATCH_IN,
  input wire logic PORT_TOGGLE_IN,
  output logic [DW-1:0] DATA_OUT,
  output logic [CNT_W-1:0] CNT_OUT,
  output logic OVF_FLAG_OUT,
  output logic START_FLAG_OUT,
  output logic WAKE_IDLE_OUT,
  output logic WAKE_ALL_OUT,
  output logic DO_OUT,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  output logic SCK_OUT,
  output logic SCK_OE_OUT
);

  // =========================================
  // Link domain: reset, pin synchronisers, edge events
  logic lrst0_r;
  logic lrst1_r;
  logic lrst_r;
  logic [SYNC_STAGES-1:0] sck_s_r;
  logic [SYNC_STAGES-1:0] sdi_s_r;
  logic sck_lvl_r;
  logic sdi_lvl_r;
  logic edge_tog_r;
  logic start_tog_r;
  ush_edge_t edge_r;

  wire sck_stable = sck_s_r[1] == sck_s_r[2];
  wire sdi_stable = sdi_s_r[1] == sdi_s_r[2];
  wire sck_change = sck_stable && (sck_s_r[2] != sck_lvl_r);
  wire sdi_fall = sdi_stable && sdi_lvl_r && !sdi_s_r[2];
  wire start_seen = sdi_fall && sck_lvl_r && !sck_change;

  always_ff @(posedge LINK_CLK_IN) begin
    lrst0_r <= SRST_IN;
    lrst1_r <= lrst0_r;
    lrst_r <= lrst1_r;
  end

  always_ff @(posedge LINK_CLK_IN) begin
    if (lrst_r) begin
      sck_s_r <= '0;
      // Idle high, so no false fall after reset
      sdi_s_r <= '1;
    end else begin
      sck_s_r <= {sck_s_r[1:0], SCK_PIN_IN};
      sdi_s_r <= {sdi_s_r[1:0], SDI_PIN_IN}; // [RULE4]
    end
  end

  always_ff @(posedge LINK_CLK_IN) begin
    if (lrst_r) begin
      sck_lvl_r <= 1'b0;
      sdi_lvl_r <= 1'b1;
      edge_tog_r <= 1'b0;
      start_tog_r <= 1'b0;
      edge_r <= '0;
    end else begin
      if (sck_stable) sck_lvl_r <= sck_s_r[2];
      if (sdi_stable) sdi_lvl_r <= sdi_s_r[2];
      if (sck_change) begin
        // Bundled with the toggle; held until the next edge
        edge_r <= '{level: sck_s_r[2], din: sdi_lvl_r};
        edge_tog_r <= !edge_tog_r;
      end
      if (start_seen) start_tog_r <= !start_tog_r; // [RULE9]
    end
  end

  // =========================================
  // Crossings into the system domain
  logic edge_evt;
  logic start_evt;

  ush_evsync u_edge_sync (
    .clk_in(MCLK_IN),
    .rst_in(SRST_IN),
    .tog_in(edge_tog_r),
    .pulse_out(edge_evt)
  );

  ush_evsync u_start_sync (
    .clk_in(MCLK_IN),
    .rst_in(SRST_IN),
    .tog_in(start_tog_r),
    .pulse_out(start_evt)
  );

  // =========================================
  // System domain pin sampling for strobe-driven shifts
  logic [SYNC_STAGES-1:0] din_s_r;
  logic din_lvl_r;

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      din_s_r <= '1;
      din_lvl_r <= 1'b1;
    end else begin
      din_s_r <= {din_s_r[1:0], SDI_PIN_IN}; // [RULE4]
      if (din_s_r[1] == din_s_r[2]) din_lvl_r <= din_s_r[2];
    end
  end

  // =========================================
  // Control state
  logic [1:0] wm_r;
  logic [1:0] src_r;
  logic esel_r;
  logic master_r;
  logic ext_lvl_r;
  logic samp_r;

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      wm_r <= WM_OFF;
      src_r <= SRC_SOFT;
      esel_r <= 1'b0;
      master_r <= 1'b0;
    end else if (CTRL_WR_IN) begin
      wm_r <= CTRL_IN.wire_mode_select;
      src_r <= CTRL_IN.clock_source_select; // [RULE8]
      esel_r <= CTRL_IN.edge_select_bit;
      master_r <= CTRL_IN.master;
    end
  end

  // =========================================
  // Clock source decode
  wire sw_shift = CTRL_WR_IN && CTRL_IN.shift_clock_strobe;
  wire sw_toggle = CTRL_WR_IN && CTRL_IN.clock_toggle_strobe;
  wire ext_src = (src_r == SRC_EXT) || (src_r == SRC_EXT_TOG);
  // Edge select 0: sample on rising, shift on falling
  wire sample_edge = edge_evt && (edge_r.level ^ esel_r); // [RULE13]
  wire shift_edge = edge_evt && !(edge_r.level ^ esel_r); // [RULE13]
  wire do_shift = (src_r == SRC_SOFT) ? sw_shift :
                  (src_r == SRC_TIMER) ? TIMER_MATCH_IN :
                  shift_edge; // [RULE8] [RULE22]
  wire do_count = (src_r == SRC_SOFT) ? sw_shift :
                  (src_r == SRC_TIMER) ? TIMER_MATCH_IN :
                  (src_r == SRC_EXT) ? edge_evt :
                  sw_toggle; // [RULE6] [RULE7] [RULE21]
  wire shift_bit = ext_src ? samp_r : din_lvl_r;
  wire two_wire = wm_r[1];
  wire latch_open = !ext_src || (ext_lvl_r == esel_r); // [RULE3]

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      ext_lvl_r <= 1'b0;
      samp_r <= 1'b0;
    end else begin
      if (edge_evt) ext_lvl_r <= edge_r.level;
      if (sample_edge) samp_r <= edge_r.din; // [RULE13]
    end
  end

  // =========================================
  // Shift register and counter
  logic [DW-1:0] sr_r;
  logic [DW-1:0] sr_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic ovf_r;
  logic start_r;

  wire cnt_wrap = do_count && (cnt_r == {CNT_W{1'b1}});

  always_comb begin
    sr_nxt = sr_r;
    if (DATA_WR_IN) sr_nxt = DATA_IN; // [RULE1]
    else if (do_shift) sr_nxt = {sr_r[DW-2:0], shift_bit}; // [RULE6]
    cnt_nxt = cnt_r;
    if (STAT_WR_IN) cnt_nxt = STAT_IN.cnt; // [RULE19] [RULE15]
    else if (do_count) cnt_nxt = cnt_r + 4'h1; // [RULE5] [RULE16]
  end

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      sr_r <= DATA_RST;
      cnt_r <= CNT_RST;
    end else begin
      sr_r <= sr_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  wire stat_clr_ovf = STAT_WR_IN && STAT_IN.ovf_clr;
  wire stat_clr_start = STAT_WR_IN && STAT_IN.start_clr;
  wire start_set = start_evt && two_wire;

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      ovf_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      if (cnt_wrap) ovf_r <= 1'b1; // [RULE16] [RULE5]
      else if (stat_clr_ovf) ovf_r <= 1'b0; // [RULE19]
      if (start_set) start_r <= 1'b1; // [RULE9]
      else if (stat_clr_start) start_r <= 1'b0;
    end
  end

  // =========================================
  // Master clock generation and output latch
  logic sck_drv_r;
  logic do_latch_r;

  wire hold_low = two_wire && (start_r || ((wm_r == WM_TWO_OVF) && ovf_r)); // [RULE10]
  wire tog_any = sw_toggle || PORT_TOGGLE_IN;

  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      sck_drv_r <= 1'b0;
      do_latch_r <= 1'b0;
    end else begin
      if (tog_any) sck_drv_r <= !sck_drv_r; // [RULE12] [RULE20]
      if (latch_open) do_latch_r <= sr_nxt[DW-1]; // [RULE3]
    end
  end

  // =========================================
  // Pin output decode
  wire wake_all_nxt = start_r || (two_wire && ovf_r); // [RULE18]
  wire do_nxt = (wm_r == WM_THREE) && do_latch_r; // [RULE2] [RULE11]
  wire sda_oe_nxt = two_wire && !do_latch_r; // [RULE2]
  wire sck_nxt = two_wire ? 1'b0 : sck_drv_r; // [RULE11]
  wire sck_oe_nxt = two_wire ? ((master_r && !sck_drv_r) || hold_low) :
                    master_r; // [RULE10]

  // =========================================
  // Registered outputs
  always_ff @(posedge MCLK_IN) begin
    if (SRST_IN) begin
      DATA_OUT <= DATA_RST;
      CNT_OUT <= CNT_RST;
      OVF_FLAG_OUT <= 1'b0;
      START_FLAG_OUT <= 1'b0;
      WAKE_IDLE_OUT <= 1'b0;
      WAKE_ALL_OUT <= 1'b0;
      DO_OUT <= 1'b0;
      SDA_OUT <= 1'b0;
      SDA_OE_OUT <= 1'b0;
      SCK_OUT <= 1'b0;
      SCK_OE_OUT <= 1'b0;
    end else begin
      DATA_OUT <= sr_r; // [RULE1]
      CNT_OUT <= cnt_r; // [RULE5]
      OVF_FLAG_OUT <= ovf_r;
      START_FLAG_OUT <= start_r;
      WAKE_IDLE_OUT <= ovf_r; // [RULE17]
      WAKE_ALL_OUT <= wake_all_nxt; // [RULE18]
      DO_OUT <= do_nxt; // [RULE2] [RULE11]
      SDA_OUT <= 1'b0;
      SDA_OE_OUT <= sda_oe_nxt; // [RULE2]
      SCK_OUT <= sck_nxt; // [RULE11]
      SCK_OE_OUT <= sck_oe_nxt; // [RULE10]
    end
  end

endmodule : ush_shift_top

// ### verification/ush_shift_asserts.sv
// Port checks for the shift block
`timescale 1ns/1ps
module ush_shift_chk
  import ush_pkg::*;
#(
  parameter int DW = DATA_W
) (
  input wire logic MCLK_IN,
  input wire logic SRST_IN,
  input wire logic DATA_WR_IN,
  input wire logic [DW-1:0] DATA_IN,
  input wire logic CTRL_WR_IN,
  input wire ush_ctrl_t CTRL_IN,
  input wire logic STAT_WR_IN,
  input wire ush_stat_t STAT_IN,
  input wire logic TIMER_MATCH_IN,
  input wire logic [DW-1:0] DATA_OUT,
  input wire logic [CNT_W-1:0] CNT_OUT,
  input wire logic OVF_FLAG_OUT,
  input wire logic WAKE_IDLE_OUT,
  input wire logic SDA_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SRST_IN);
  wire stb = CTRL_WR_IN && CTRL_IN.shift_clock_strobe
    && CTRL_IN.clock_source_select == SRC_SOFT;
  // ==========
  // Assertions
  cnt_step_a: assert property (
    stb && !STAT_WR_IN |-> ##2 CNT_OUT == $past(CNT_OUT) + 1'b1) else $error("cnt step");
  shift_step_a: assert property (
    stb && !DATA_WR_IN |-> ##2 DATA_OUT[DW-1:1] == $past(DATA_OUT[DW-2:0]))
    else $error("shift step");
  data_load_a: assert property (
    DATA_WR_IN |-> ##2 DATA_OUT == $past(DATA_IN, 2)) else $error("data load");
  cnt_load_a: assert property (
    STAT_WR_IN |-> ##2 CNT_OUT == $past(STAT_IN.cnt, 2)) else $error("cnt load");
  ovf_set_a: assert property (
    CNT_OUT == 4'hf ##1 (CNT_OUT == 4'h0 && !$past(STAT_WR_IN, 2)) |-> OVF_FLAG_OUT)
    else $error("ovf set");
  ovf_clear_a: assert property (
    STAT_WR_IN && STAT_IN.ovf_clr && !CTRL_WR_IN && !TIMER_MATCH_IN |-> ##2 !OVF_FLAG_OUT)
    else $error("ovf clear");
  wake_idle_a: assert property (
    WAKE_IDLE_OUT == OVF_FLAG_OUT) else $error("wake idle");
  sda_low_a: assert property (
    SDA_OUT == 1'b0) else $error("sda value");
  cover property (OVF_FLAG_OUT && CNT_OUT == 4'h0);
  cover property (DATA_WR_IN && stb);
  cover property (TIMER_MATCH_IN);
endmodule : ush_shift_chk

bind ush_shift_top ush_shift_chk #(.DW(DW)) chk_u (.*);

// ### verification/ush_spi_master.sv
// External serial master model, mode 0
`timescale 1ns/1ps
module ush_spi_master (
  input wire logic lclk_in,
  input wire logic go_in,
  input wire logic [7:0] tx_in,
  input wire logic do_in,
  output logic sck_out,
  output logic sdi_out,
  output logic [7:0] rx_out,
  output logic done_out
);
  initial {sck_out, sdi_out, rx_out, done_out} = 11'h200;
  task automatic wt();
    repeat (8) @(posedge lclk_in);
    #1;
  endtask : wt
  // Clock runs only inside a frame, idles low
  always @(posedge go_in) begin
    done_out = 0;
    for (int i = 7; i >= 0; i--) begin
      sdi_out = tx_in[i];
      wt();
      sck_out = 1;
      rx_out = {rx_out[6:0], do_in};
      wt();
      sck_out = 0;
    end
    wt();
    sdi_out = ~sdi_out;
    done_out = 1;
  end
endmodule : ush_spi_master

// ### verification/universal_shift_serial_three_wire_tb_top.sv
// Self-checking bench for the universal shift block
`timescale 1ns/1ps
module universal_shift_serial_three_wire_tb_top;
  import ush_pkg::*;
  logic mclk = 0, lclk = 0, srst = 1, dwr = 0, cwr = 0, swr = 0, tmr = 0, go = 0;
  logic done, dout, sck, sdi, ovf;
  logic ptg = 0, stf, wki, wka, sck_o, sck_oe;
  logic [7:0] din = 0, tx = 0, dat, rx;
  logic [3:0] cnt;
  ush_ctrl_t ctl = '0;
  ush_stat_t st = '0;
  logic [31:0] seed = 32'h0000_b788;
  logic [10:0] q[$];
  string nm[6] = '{"data", "count", "ovf", "rx", "sck", "wake"};
  int errors = 0;
  int cmp_count = 0;
  event obs_e;
  always #5 mclk = ~mclk;
  initial begin
    #2.3;
    forever #7.5 lclk = ~lclk;
  end
  ush_shift_top dut_u (
    .MCLK_IN(mclk), .SRST_IN(srst), .LINK_CLK_IN(lclk), .SCK_PIN_IN(sck),
    .SDI_PIN_IN(sdi), .DATA_WR_IN(dwr), .DATA_IN(din), .CTRL_WR_IN(cwr), .CTRL_IN(ctl),
    .STAT_WR_IN(swr), .STAT_IN(st), .TIMER_MATCH_IN(tmr), .PORT_TOGGLE_IN(ptg),
    .DATA_OUT(dat), .CNT_OUT(cnt), .OVF_FLAG_OUT(ovf), .START_FLAG_OUT(stf),
    .WAKE_IDLE_OUT(wki), .WAKE_ALL_OUT(wka), .DO_OUT(dout), .SDA_OUT(), .SDA_OE_OUT(),
    .SCK_OUT(sck_o), .SCK_OE_OUT(sck_oe)
  );
  ush_spi_master peer_u (.lclk_in(lclk), .go_in(go), .tx_in(tx), .do_in(dout),
    .sck_out(sck), .sdi_out(sdi), .rx_out(rx), .done_out(done));
  // ==========
  // Helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  function automatic ush_ctrl_t mk(input logic [1:0] s, input logic b, input logic t);
    return ush_ctrl_t'({WM_THREE, s, 1'b0, s == SRC_SOFT, b, t});
  endfunction : mk
  task automatic drv(input logic c, input logic s, input logic d, input ush_ctrl_t k,
      input logic [7:0] v);
    cwr = c;
    swr = s;
    dwr = d;
    ctl = k;
    st = ush_stat_t'(v[5:0]);
    din = v;
    @(posedge mclk);
    #1;
  endtask : drv
  task automatic chk(input logic [2:0] k, input logic [7:0] e);
    q.push_back({k, e});
    repeat (3) @(posedge mclk);
    #1;
    ->obs_e;
  endtask : chk
  always @(obs_e) begin : mon
    logic [10:0] n;
    logic [7:0] g;
    n = q.pop_front();
    g = n[10:8] == 0 ? dat : n[10:8] == 1 ? {4'h0, cnt} : n[10:8] == 2 ? {7'h0, ovf} :
        n[10:8] == 3 ? rx : n[10:8] == 4 ? {6'h0, sck_oe, sck_o} : {5'h0, stf, wka, wki};
    cmp_count++;
    if (g !== n[7:0]) begin
      errors++;
      $display("Error %s exp %h got %h", nm[n[10:8]], n[7:0], g);
    end
  end
  task automatic test_done();
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done
  // ==========
  // Scenarios
  initial begin : main
    ush_ctrl_t c;
    logic [7:0] v;
    int n;
    repeat (8) @(posedge mclk);
    #1;
    srst = 0;
    chk(0, 8'h00);
    chk(1, 8'h00);
    // Fast software master
    c = mk(SRC_SOFT, 0, 0);
    drv(1, 0, 1, c, 8'h00);
    drv(0, 1, 0, c, 8'h20);
    for (int i = 0; i < 16; i++) drv(1, 0, 0, mk(SRC_SOFT, i[0], 1), 8'h00);
    drv(0, 0, 0, c, 8'h00);
    chk(0, 8'hff);
    chk(1, 8'h08);
    chk(4, 8'h02);
    ptg = 1;
    drv(0, 0, 0, c, 8'h00);
    ptg = 0;
    chk(4, 8'h03);
    $display("test soft_fast done");
    // Wrap from a loaded count
    drv(0, 1, 0, c, 8'h2e);
    drv(1, 0, 0, mk(SRC_SOFT, 1, 0), 8'h00);
    drv(1, 0, 0, mk(SRC_SOFT, 1, 0), 8'h00);
    drv(0, 0, 0, c, 8'h00);
    chk(1, 8'h00);
    chk(2, 8'h01);
    chk(5, 8'h01);
    drv(0, 1, 0, c, 8'h23);
    drv(0, 0, 0, c, 8'h00);
    chk(2, 8'h00);
    chk(1, 8'h03);
    $display("test wrap done");
    // Data write beats a same-cycle shift
    v = rnd();
    drv(1, 0, 1, mk(SRC_SOFT, 1, 0), v);
    drv(0, 0, 0, c, 8'h00);
    chk(0, v);
    $display("test collide done");
    // Timer match clocking
    c = mk(SRC_TIMER, 0, 0);
    n = rnd() % 7 + 1;
    drv(1, 0, 1, c, 8'h00);
    drv(0, 1, 0, c, 8'h20);
    drv(0, 0, 0, c, 8'h00);
    repeat (n) begin
      tmr = 1;
      @(posedge mclk);
      #1;
      tmr = 0;
      @(posedge mclk);
      #1;
    end
    chk(1, 8'(n));
    chk(0, 8'((1 << n) - 1));
    $display("test timer done");
    // External master frame
    c = mk(SRC_EXT, 0, 0);
    v = rnd();
    tx = rnd();
    drv(1, 0, 1, c, v);
    drv(0, 1, 0, c, 8'h20);
    drv(0, 0, 0, c, 8'h00);
    go = 1;
    for (n = 0; n < 4000 && done !== 1'b1; n++) @(posedge mclk);
    go = 0;
    if (done !== 1'b1) begin
      errors++;
      test_done();
    end
    chk(0, tx);
    chk(1, 8'h00);
    chk(2, 8'h01);
    chk(3, v);
    $display("test ext_frame done");
    @(posedge mclk);
    test_done();
  end
endmodule : universal_shift_serial_three_wire_tb_top
